// File: rtl/vsp_pkg.sv
/*
 * Shared constants and carrier types for the video stream port.
 * Assumes one core clock; component width is fixed at build time.
 */
`default_nettype none
package vsp_pkg;
    // Bits per colour component (8, 10 or 12)
    localparam int VSP_COMP_W   = 8;
    // Three components packed side by side
    localparam int VSP_ACT_W    = 3 * VSP_COMP_W;
    // Stream word rounded up to whole bytes
    localparam int VSP_TDATA_W  = ((VSP_ACT_W + 7) / 8) * 8;
    // Mask of live bits; bits above it are padding
    localparam logic [VSP_TDATA_W-1:0] VSP_PAD_MASK =
        {VSP_TDATA_W{1'b1}} >> (VSP_TDATA_W - VSP_ACT_W);
    // Pipeline flush after each line, in core cycles
    localparam int VSP_LINE_FLUSH = 26;
    // Default active picture size
    localparam int VSP_COLS     = 1920;
    localparam int VSP_ROWS     = 1080;
    // Buffer depth in beats
    localparam int VSP_FIFO_DEPTH = 4;
    // Counter widths
    localparam int VSP_CNT_W    = 16;
    // Reset values
    localparam logic [VSP_CNT_W-1:0] VSP_CNT_RST = 16'h0000;

    // One stream beat with its framing flags
    typedef struct packed {
        logic                   frame_start;   // First pixel of frame
        logic                   line_end_flag; // Last pixel of line
        logic [VSP_TDATA_W-1:0] data;          // Packed components
    } vsp_beat_t;

    // Zero every bit above the live components
    function automatic logic [VSP_TDATA_W-1:0] vsp_pad(
        input logic [VSP_TDATA_W-1:0] w);
        vsp_pad = w & VSP_PAD_MASK;
    endfunction
endpackage
`default_nettype wire

// File: rtl/vsp_port.sv
/*
 * Video stream port: slave input, four-beat buffer, master output,
 * with line and frame flush stalls on the input ready.
 * Assumes stream partners are synchronous logic on i_mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module vsp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         i_mclk,   // Core clock
    input  wire logic         i_rstn,   // Async reset, low
    input  wire logic         i_ce,     // Clock enable
    input  wire logic [W-1:0] i_data,   // Write word
    input  wire logic         i_valid,  // Write request
    output logic              o_ready,  // Room available
    output logic [W-1:0]      o_data,   // Head word
    output logic              o_valid,  // Head present
    input  wire logic         i_ready   // Reader takes head
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];   // Storage
    logic [AW-1:0] wr_ptr;        // Next write slot
    logic [AW-1:0] rd_ptr;        // Head slot
    logic [AW:0]   count;         // Words held
    logic          push;          // Write this edge
    logic          pop;           // Read this edge

    // Handshakes come straight from held state
    assign o_ready = (count != (AW + 1)'(DEPTH));
    assign o_valid = (count != '0);
    assign o_data  = mem[rd_ptr];
    assign push    = i_valid && o_ready && i_ce;
    assign pop     = o_valid && i_ready && i_ce;

    // Storage writes; no reset needed for data
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    property p_push_count;
        push && !pop |=> count == $past(count) + 1'b1;
    endproperty
    a_push_count: assert property (p_push_count)
        else $error("fill level did not grow on push");

    property p_no_sample;
        !i_ce |=> $stable(count) && $stable(wr_ptr);
    endproperty
    a_no_sample: assert property (p_no_sample)
        else $error("buffer changed with enable low");

    c_full: cover property (count == (AW + 1)'(DEPTH));
endmodule

module vsp_port
    import vsp_pkg::*;
#(
    parameter int ACTIVE_COLS = vsp_pkg::VSP_COLS,      // Pixels per line
    parameter int ACTIVE_ROWS = vsp_pkg::VSP_ROWS,      // Lines per frame
    parameter int LINE_FLUSH  = vsp_pkg::VSP_LINE_FLUSH // Line flush cycles
) (
    input  wire logic                       i_mclk,     // Core clock
    input  wire logic                       i_rstn,     // Async reset, low
    input  wire logic                       i_ce,       // Clock enable
    input  wire logic [vsp_pkg::VSP_TDATA_W-1:0] i_s_tdata, // In pixel
    input  wire logic                       i_s_tvalid, // In valid
    output logic                            o_s_tready, // In ready
    input  wire logic                       i_s_tuser,  // In frame start
    input  wire logic                       i_s_tlast,  // In line end
    output logic [vsp_pkg::VSP_TDATA_W-1:0] o_m_tdata,  // Out pixel
    output logic                            o_m_tvalid, // Out valid
    input  wire logic                       i_m_tready, // Out ready
    output logic                            o_m_tuser,  // Out frame start
    output logic                            o_m_tlast   // Out line end
);
    import vsp_pkg::*;

    // Flush lengths; frame end adds one whole line period
    localparam logic [VSP_CNT_W-1:0] LINE_LOAD = VSP_CNT_W'(LINE_FLUSH);
    localparam logic [VSP_CNT_W-1:0] FRAME_LOAD =
        VSP_CNT_W'(LINE_FLUSH + ACTIVE_COLS + LINE_FLUSH);
    localparam logic [VSP_CNT_W-1:0] LAST_ROW = VSP_CNT_W'(ACTIVE_ROWS - 1);
    localparam int LINE_CHK  = LINE_FLUSH;
    localparam int FRAME_CHK = LINE_FLUSH + ACTIVE_COLS + LINE_FLUSH;

    vsp_beat_t              in_beat;    // Beat entering buffer
    vsp_beat_t              out_beat;   // Beat at buffer head
    logic                   fifo_ready; // Buffer has room
    logic                   fifo_valid; // Ask buffer to store
    logic                   accept;     // Input beat taken
    logic                   frame_end;  // Input beat ends frame
    logic [VSP_CNT_W-1:0]   flush_cnt;  // Stall cycles left
    logic [VSP_CNT_W-1:0]   row_cnt;    // Current line index

    // constant build, no control or interrupt ports
    // nothing here touches a control-side clock domain

    // padding cleared even if source left junk
    // framing flags travel with the pixel
    assign in_beat.data          = vsp_pad(i_s_tdata);
    assign in_beat.frame_start   = i_s_tuser;
    assign in_beat.line_end_flag = i_s_tlast;

    assign o_s_tready = fifo_ready && (flush_cnt == VSP_CNT_RST);
    // the beat counts only with enable high
    assign accept     = i_s_tvalid && o_s_tready && i_ce;
    // Valid into buffer is gated by the flush stall too
    assign fifo_valid = i_s_tvalid && (flush_cnt == VSP_CNT_RST);
    assign frame_end  = i_s_tlast && (row_cnt == LAST_ROW) && !i_s_tuser;

    // Line position within the frame
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            row_cnt <= VSP_CNT_RST;
        end else if (i_ce && accept) begin
            if (i_s_tuser && i_s_tlast) begin
                row_cnt <= VSP_CNT_W'(1);
            end else if (i_s_tuser) begin
                row_cnt <= VSP_CNT_RST;
            end else if (i_s_tlast) begin
                row_cnt <= frame_end ? VSP_CNT_RST : row_cnt + 1'b1;
            end
        end
    end

    // Flush stall counter; a flat counter is cheaper than a state machine
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            // reset clears stall regardless of enable
            flush_cnt <= VSP_CNT_RST;
        end else if (i_ce) begin
            if (accept && i_s_tlast) begin
                // frame end stalls one extra line
                flush_cnt <= frame_end ? FRAME_LOAD : LINE_LOAD;
            end else if (flush_cnt != VSP_CNT_RST) begin
                flush_cnt <= flush_cnt - 1'b1;
            end
        end
    end

    // Buffer between input and output streams
    vsp_fifo #(
        .W     ($bits(vsp_beat_t)),
        .DEPTH (VSP_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_ce    (i_ce),
        .i_data  (in_beat),
        .i_valid (fifo_valid),
        .o_ready (fifo_ready),
        .o_data  (out_beat),
        .o_valid (o_m_tvalid),
        .i_ready (i_m_tready)
    );

    // head held in storage until popped
    assign o_m_tdata = out_beat.data;
    assign o_m_tuser = out_beat.frame_start;
    assign o_m_tlast = out_beat.line_end_flag;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    property p_freeze;
        !i_ce |=> $stable(o_m_tvalid) && $stable(o_m_tdata)
              && $stable(o_s_tready) && $stable(flush_cnt);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with enable low");

    property p_line_flush;
        accept && i_s_tlast && !frame_end |=> flush_cnt == LINE_CHK;
    endproperty
    a_line_flush: assert property (p_line_flush)
        else $error("line flush length wrong");

    property p_frame_flush;
        accept && frame_end |=> flush_cnt == FRAME_CHK;
    endproperty
    a_frame_flush: assert property (p_frame_flush)
        else $error("frame flush length wrong");

    property p_stall_ready;
        flush_cnt != VSP_CNT_RST |-> !o_s_tready;
    endproperty
    a_stall_ready: assert property (p_stall_ready)
        else $error("ready high during flush");

    property p_hold;
        o_m_tvalid && !i_m_tready |=> o_m_tvalid && $stable(o_m_tdata)
            && $stable(o_m_tuser) && $stable(o_m_tlast);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled output changed");

    property p_pad;
        o_m_tvalid |-> (o_m_tdata & ~VSP_PAD_MASK) == '0;
    endproperty
    a_pad: assert property (p_pad)
        else $error("output padding not zero");

    // Must stay live during reset, so the default disable is overridden
    property p_reset;
        @(posedge i_mclk) disable iff (1'b0)
            !i_rstn |-> !o_m_tvalid && flush_cnt == '0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not clear core");

    c_line_flush: cover property (accept && i_s_tlast && !frame_end);
    c_frame_flush: cover property (accept && frame_end);
    c_backpress: cover property (o_m_tvalid && !i_m_tready && !o_s_tready);
endmodule
`default_nettype wire

// File: sim/vsp_port_tb.sv
/*
 * Self-checking bench for the video stream port.
 * Assumes the design's own assertions guard output stability.
 */
`timescale 1ns/1ps
`default_nettype none
module vsp_port_tb;
    import vsp_pkg::*;
    localparam int COLS = 8;  // Short lines keep the run brief
    localparam int ROWS = 4;  // Short frames likewise
    localparam int FL   = 26; // Line flush length
    logic i_mclk = 0, i_ce = 1, s_valid = 0;
    logic i_rstn; // Driven at time zero so the reset edge is seen
    logic s_ready, m_valid, m_ready;
    logic [1:0] mode = 2'h0; // Sink behaviour
    vsp_beat_t s_beat = '0, b;
    wire vsp_beat_t m_beat; // Output beat, one port per field
    int bad_count = 0, n_tests = 0, cyc = 0, n;
    vsp_beat_t exp_q[$];      // Expected output order
    // source words carry zero padding
    // Rows: input word, expected output word
    logic [VSP_TDATA_W-1:0] tab [COLS][2] = '{
        '{24'h000000, 24'h000000}, '{24'hffffff, 24'hffffff},
        '{24'ha5a5a5, 24'ha5a5a5}, '{24'h5a5a5a, 24'h5a5a5a},
        '{24'h010203, 24'h010203}, '{24'h800001, 24'h800001},
        '{24'h7fff00, 24'h7fff00}, '{24'hc3c3c3, 24'hc3c3c3}};

    vsp_port #(.ACTIVE_COLS(COLS), .ACTIVE_ROWS(ROWS),
        .LINE_FLUSH(FL)) u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_ce(i_ce), .i_s_tdata(s_beat.data), .i_s_tvalid(s_valid),
        .o_s_tready(s_ready), .i_s_tuser(s_beat.frame_start),
        .i_s_tlast(s_beat.line_end_flag), .o_m_tdata(m_beat.data),
        .o_m_tvalid(m_valid), .i_m_tready(m_ready),
        .o_m_tuser(m_beat.frame_start),
        .o_m_tlast(m_beat.line_end_flag));
    vsp_sink_model u_sink (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_ce(i_ce), .i_valid(m_valid), .i_beat(m_beat),
        .i_mode(mode), .o_ready(m_ready));

    // Clock and hang guard
    always #2.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc >= 20000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            give_verdict;
        end
    end

    task automatic chk_beat(input vsp_beat_t g, e, input string w);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: %s %h want %h", $time, w, g, e);
        end
    endtask
    task automatic chk_num(input logic [15:0] g, e, input string w);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: %s %0d want %0d", $time, w, g, e);
        end
    endtask
    task automatic send(input vsp_beat_t v);
        int k;
        k = 0;
        s_beat  <= v;
        s_valid <= 1'b1;
        do begin
            @(posedge i_mclk);
            k++;
        end while (!(s_ready === 1'b1 && i_ce === 1'b1) && k < 500);
        if (k >= 500) begin
            bad_count++;
            $display("unexpected at %0t: beat never taken", $time);
        end
    endtask
    task automatic idle;
        s_valid <= 1'b0;
        s_beat  <= ~s_beat;
    endtask
    task automatic flush_len(output int c);
        c = 0;
        @(posedge i_mclk);
        while (s_ready === 1'b0 && c < 500) begin
            c++;
            @(posedge i_mclk);
        end
    endtask
    task automatic drain(input int num, input string w);
        int k;
        k = 0;
        while (u_sink.got.size() < num && k < 500) begin
            @(posedge i_mclk);
            k++;
        end
        chk_num(16'(u_sink.got.size()), 16'(num), {w, " count"});
        foreach (exp_q[i]) begin
            if (i < u_sink.got.size()) chk_beat(u_sink.got[i], exp_q[i], w);
        end
        u_sink.got.delete();
        exp_q.delete();
        $display("test %s done", w);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        i_rstn <= 1'b0;
        repeat (6) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(posedge i_mclk);
        // Table loop over one frame
        for (int r = 0; r < ROWS; r++) begin
            mode <= (r < 2) ? 2'h1 : 2'h0;
            for (int i = 0; i < COLS; i++) begin
                b = '{(r == 0 && i == 0), (i == COLS - 1), tab[i][0]};
                exp_q.push_back('{b.frame_start, b.line_end_flag, tab[i][1]});
                send(b);
            end
            idle;
            flush_len(n);
            chk_num(16'(n), 16'((r == ROWS - 1) ? 2 * FL + COLS : FL), "flush");
        end
        drain(ROWS * COLS, "frame");
        // Fill buffer with sink stalled, then freeze
        mode <= 2'h2;
        for (int i = 0; i < VSP_FIFO_DEPTH; i++) begin
            b = '{1'b0, 1'b0, tab[i][0]};
            exp_q.push_back('{1'b0, 1'b0, tab[i][1]});
            send(b);
        end
        idle;
        @(posedge i_mclk);
        chk_num({15'h0, s_ready}, 16'h0, "full ready");
        i_ce <= 1'b0;
        mode <= 2'h0;
        repeat (5) @(posedge i_mclk);
        chk_num({15'h0, m_valid}, 16'h1, "frozen valid");
        chk_num(16'(u_sink.got.size()), 16'h0, "frozen taken");
        i_ce <= 1'b1;
        drain(VSP_FIFO_DEPTH, "fill");
        // Reset with enable low, beats pending
        mode <= 2'h2;
        send('{1'b1, 1'b0, tab[2][0]});
        send('{1'b0, 1'b0, tab[3][0]});
        idle;
        i_ce   <= 1'b0;
        i_rstn <= 1'b0;
        repeat (32) @(posedge i_mclk);
        chk_num({15'h0, m_valid}, 16'h0, "reset valid");
        chk_num({15'h0, s_ready}, 16'h1, "reset ready");
        i_rstn <= 1'b1;
        i_ce   <= 1'b1;
        mode   <= 2'h0;
        u_sink.got.delete();
        @(posedge i_mclk);
        exp_q.push_back('{1'b1, 1'b0, tab[5][1]});
        send('{1'b1, 1'b0, tab[5][0]});
        idle;
        drain(1, "reset");
        give_verdict;
    end
endmodule
`default_nettype wire

// File: sim/vsp_sink_model.sv
/*
 * Downstream video sink model: takes output beats into a queue.
 * Assumes the bench selects its ready behaviour through i_mode.
 */
`timescale 1ns/1ps
`default_nettype none
module vsp_sink_model
    import vsp_pkg::*;
(
    input  wire logic      i_mclk,  // Core clock
    input  wire logic      i_rstn,  // Async reset, low
    input  wire logic      i_ce,    // Clock enable
    input  wire logic      i_valid, // Beat offered
    input  wire vsp_beat_t i_beat,  // Beat contents
    input  wire logic [1:0] i_mode, // 0 eager, 1 registered, 2 stall
    output logic           o_ready  // Sink ready
);
    vsp_beat_t got[$];  // Beats taken, in order
    logic      reg_rdy; // Ready raised a cycle after valid

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            reg_rdy <= 1'b0;
        end else if (i_ce) begin
            reg_rdy <= i_valid && !reg_rdy;
        end
    end

    assign o_ready = (i_mode == 2'h0) ? 1'b1 :
                     (i_mode == 2'h1) ? reg_rdy : 1'b0;

    always @(posedge i_mclk) begin
        if (i_rstn && i_ce && i_valid && o_ready) begin
            got.push_back(i_beat);
        end
    end
endmodule
`default_nettype wire
